// ==== ebac_pkg.sv ====
// Purpose: constants and types for the byte-wide non-volatile store controller
// Assumes: core data space of two banks, special registers below SFR_TOP
// Notes:   bus offsets of the location, buffer and bank registers decode the same in both banks
package ebac_pkg;

	// ==================================================================
	// register placement
	localparam logic [7:0] OFS_LOC     = 8'h1e;
	localparam logic [7:0] OFS_BUF     = 8'h1f;
	localparam logic [7:0] OFS_BANK    = 8'h04;
	localparam logic [7:0] OFS_CTRL    = 8'h40;
	localparam logic       BANK_CTRL   = 1'h1;
	localparam logic [7:0] SFR_TOP     = 8'h40;

	// ==================================================================
	// control field positions and reset values
	localparam int         CTL_RD      = 0;
	localparam int         CTL_READ_ENABLE    = 1;
	localparam int         CTL_WT      = 2;
	localparam int         CTL_WRITE_ENABLE    = 3;
	localparam logic [7:0] RST_LOC     = 8'h00;
	localparam logic [7:0] RST_BUF     = 8'h00;
	localparam logic       RST_BANK    = 1'h0;

	// ==================================================================
	// store geometry and timing
	localparam int         NVM_DEPTH   = 32;
	localparam int         NVM_AW      = 5;
	localparam int         CLK_PERIOD_NS = 20;
	localparam int         READ_TIME_NS  = 40;
	localparam int         READ_CYCLES =
		(READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         TICK_DIV    = 8;
	localparam int         WRITE_TICKS = 12;

	// ==================================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_READ  = 3'h2,
		ST_WRITE = 3'h4
	} ebac_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       indirect;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ebac_bus_req_t;

endpackage : ebac_pkg

// ==== ebac_nvm_ctrl.sv ====
// Purpose: 32 x 8 non-volatile store reached through location, buffer and
//          control registers on the core data bus
// Assumes: core resolves indirect pointers and presents effective address
// Notes:   read data of a bus read is returned one cycle later
//
// Summary of operation
// - 32 bytes, reached only through registers
// - location register five bits, upper read zero
// - location and buffer sit in special space
// - control at 40H bank 1, indirect only
// - write enable low blocks every write
// - read enable low blocks every read
// - write start launches write, self-clears at end
// - read start launches read, self-clears at end
// - write start ignored unless enable already set
// - read start ignored unless enable already set
// - control upper four bits zero, others cleared
// - buffer full byte, cleared at power-on
// - fetched byte held until next operation
// - write length set by free-running internal timer
// - write end seen by start bit and flag
// - write enable cleared at power-on
// - bank select resets to bank zero
// - write end sets own and shared flags
module ebac_nvm_ctrl
	import ebac_pkg::*;
#(
	parameter int RD_CYCLES = READ_CYCLES,
	parameter int TICK_DIVIDE = TICK_DIV,
	parameter int WR_TICKS = WRITE_TICKS
) (
	input  wire logic          clk_sys,
	input  wire logic          reset,
	input  wire ebac_bus_req_t busReq,
	output logic [7:0]         busRdata,
	output logic               busRvalid,
	input  wire logic          nvmIrqClear,
	input  wire logic          multiFuncClear,
	output logic               nvmIrqFlag,
	output logic               multiFuncFlag
);

	// ==================================================================
	// decode
	function automatic logic regHit(ebac_bus_req_t r, logic bank,
		logic [7:0] ofs, logic ofsBank);
		logic effBank;
		effBank = r.indirect & bank;
		if (ofs < SFR_TOP)
			regHit = (r.addr == ofs);
		else
			regHit = (r.addr == ofs) && (effBank == ofsBank);
	endfunction : regHit

	ebac_state_t       stateReg;
	logic              bankSelReg;
	logic [NVM_AW-1:0] locReg;
	logic [7:0]        bufReg;
	logic              wrEnReg;
	logic              rdEnReg;
	logic [NVM_AW-1:0] capAddrReg;
	logic [7:0]        capDataReg;
	logic [7:0]        nvmMem [NVM_DEPTH];
	logic [7:0]        rdCntReg;
	logic [7:0]        tickCntReg;
	logic [7:0]        wrTickReg;
	logic [7:0]        ctrlView;
	logic              hitLoc, hitBuf, hitBank, hitCtrl;
	logic              startWr, startRd, readDone, writeDone, timerTick;
	logic              rdCtrlReg;

	assign hitLoc  = regHit(busReq, bankSelReg, OFS_LOC, 1'h0);
	assign hitBuf  = regHit(busReq, bankSelReg, OFS_BUF, 1'h0);
	assign hitBank = regHit(busReq, bankSelReg, OFS_BANK, 1'h0);
	assign hitCtrl = regHit(busReq, bankSelReg, OFS_CTRL, BANK_CTRL);

	// start bits read back as busy state, so clearing is automatic
	always_comb begin
		ctrlView           = 8'h00;
		ctrlView[CTL_WRITE_ENABLE] = wrEnReg;
		ctrlView[CTL_READ_ENABLE] = rdEnReg;
		ctrlView[CTL_WT]   = (stateReg == ST_WRITE);
		ctrlView[CTL_RD]   = (stateReg == ST_READ);
	end

	// enables judged on their old value: same-write set does not count
	assign startWr = busReq.wr && hitCtrl && stateReg == ST_IDLE &&
		busReq.wdata[CTL_WT] && wrEnReg;
	assign startRd = busReq.wr && hitCtrl && stateReg == ST_IDLE &&
		busReq.wdata[CTL_RD] && rdEnReg && !startWr;

	// ==================================================================
	// software registers
	always_ff @(posedge clk_sys) begin
		if (reset)
			bankSelReg <= RST_BANK;
		else if (busReq.wr && hitBank)
			bankSelReg <= busReq.wdata[0];
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			locReg <= RST_LOC[NVM_AW-1:0];
		else if (busReq.wr && hitLoc)
			locReg <= busReq.wdata[NVM_AW-1:0];
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wrEnReg <= 1'h0;
			rdEnReg <= 1'h0;
		end else if (busReq.wr && hitCtrl) begin
			wrEnReg <= busReq.wdata[CTL_WRITE_ENABLE];
			rdEnReg <= busReq.wdata[CTL_READ_ENABLE];
		end
	end

	// read completion has priority over a software store in that cycle
	always_ff @(posedge clk_sys) begin
		if (reset)
			bufReg <= RST_BUF;
		else if (readDone)
			bufReg <= nvmMem[capAddrReg];
		else if (busReq.wr && hitBuf)
			bufReg <= busReq.wdata;
	end

	// ==================================================================
	// bus read path
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			busRdata  <= 8'h00;
			busRvalid <= 1'h0;
			rdCtrlReg <= 1'h0;
		end else begin
			busRvalid <= busReq.rd;
			rdCtrlReg <= busReq.rd && hitCtrl;
			if (!busReq.rd)
				busRdata <= 8'h00;
			else if (hitLoc)
				busRdata <= {3'h0, locReg};
			else if (hitBuf)
				busRdata <= bufReg;
			else if (hitBank)
				busRdata <= {7'h00, bankSelReg};
			else if (hitCtrl)
				busRdata <= ctrlView;
			else
				busRdata <= 8'h00;
		end
	end

	// ==================================================================
	// write timer, free running so write ends unaligned to its start
	assign timerTick = (tickCntReg == 8'(TICK_DIVIDE - 1));

	always_ff @(posedge clk_sys) begin
		if (reset || timerTick)
			tickCntReg <= 8'h00;
		else
			tickCntReg <= tickCntReg + 8'h01;
	end

	assign readDone  = (stateReg == ST_READ) &&
		(rdCntReg == 8'(RD_CYCLES - 1));
	assign writeDone = (stateReg == ST_WRITE) && timerTick &&
		(wrTickReg == 8'(WR_TICKS - 1));

	// ==================================================================
	// cycle sequencer
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stateReg   <= ST_IDLE;
			rdCntReg   <= 8'h00;
			wrTickReg  <= 8'h00;
			capAddrReg <= '0;
			capDataReg <= 8'h00;
		end else begin
			case (stateReg)
			ST_IDLE: begin
				rdCntReg  <= 8'h00;
				wrTickReg <= 8'h00;
				if (startWr || startRd) begin
					capAddrReg <= locReg;
					capDataReg <= bufReg;
				end
				if (startWr)
					stateReg <= ST_WRITE;
				else if (startRd)
					stateReg <= ST_READ;
			end
			ST_READ: begin
				rdCntReg <= rdCntReg + 8'h01;
				if (readDone)
					stateReg <= ST_IDLE;
			end
			ST_WRITE: begin
				if (timerTick)
					wrTickReg <= wrTickReg + 8'h01;
				if (writeDone)
					stateReg <= ST_IDLE;
			end
			default: stateReg <= ST_IDLE;
			endcase
		end
	end

	// contents survive reset: this is the non-volatile array
	always_ff @(posedge clk_sys) begin
		if (writeDone)
			nvmMem[capAddrReg] <= capDataReg;
	end

	// ==================================================================
	// completion flags, set beats clear
	always_ff @(posedge clk_sys) begin
		if (reset)
			nvmIrqFlag <= 1'h0;
		else if (writeDone)
			nvmIrqFlag <= 1'h1;
		else if (nvmIrqClear)
			nvmIrqFlag <= 1'h0;
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			multiFuncFlag <= 1'h0;
		else if (writeDone)
			multiFuncFlag <= 1'h1;
		else if (multiFuncClear)
			multiFuncFlag <= 1'h0;
	end

	// ==================================================================
	// checks
	// bound covers the slowest timer phase at default parameters
	localparam int WR_MAX = 120;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_wr_needs_en: assert property (
		$rose(stateReg == ST_WRITE) |-> $past(wrEnReg))
		else $error("write began without prior enable");
	a_rd_needs_en: assert property (
		$rose(stateReg == ST_READ) |-> $past(rdEnReg))
		else $error("read began without prior enable");
	a_rd_length: assert property (
		$rose(stateReg == ST_READ) |-> (stateReg == ST_READ)[*2]
		##1 stateReg == ST_IDLE)
		else $error("read cycle length wrong");
	a_rd_data: assert property (
		readDone |=> bufReg == $past(nvmMem[capAddrReg]))
		else $error("fetched byte not in buffer");
	a_buf_hold: assert property (
		!readDone && !(busReq.wr && hitBuf) |=> $stable(bufReg))
		else $error("buffer changed without cause");
	a_wr_bounded: assert property (
		$rose(stateReg == ST_WRITE) |-> ##[1:WR_MAX] stateReg == ST_IDLE)
		else $error("write cycle never finished");
	a_wr_flags: assert property (
		writeDone |=> nvmIrqFlag && multiFuncFlag && !ctrlView[CTL_WT])
		else $error("write end flags missing");
	a_wr_commit: assert property (
		writeDone |=> nvmMem[$past(capAddrReg)] == $past(capDataReg))
		else $error("captured byte not stored");
	a_ctrl_upper: assert property (
		busRvalid && rdCtrlReg |-> busRdata[7:4] == 4'h0)
		else $error("control upper bits not zero");
	a_reset_safe: assert property (
		$past(reset) |-> !bankSelReg && !wrEnReg && stateReg == ST_IDLE)
		else $error("unsafe state after reset");

	// enables and capture watched at the decision, not only the result
	a_wr_blocked: assert property (
		stateReg == ST_IDLE && !wrEnReg |=> stateReg != ST_WRITE)
		else $error("write began with enable low");
	a_rd_blocked: assert property (
		stateReg == ST_IDLE && !rdEnReg |=> stateReg != ST_READ)
		else $error("read began with enable low");
	a_cap_stable: assert property (
		stateReg != ST_IDLE |=>
		$stable(capAddrReg) && $stable(capDataReg))
		else $error("captured location or byte moved");
	a_rd_no_flag: assert property (
		readDone && !nvmIrqFlag && !multiFuncFlag |=>
		!nvmIrqFlag && !multiFuncFlag)
		else $error("read end raised a write flag");
	a_flag_sticky: assert property (
		nvmIrqFlag && !nvmIrqClear |=> nvmIrqFlag)
		else $error("store flag dropped without clear");

	c_write: cover property ($rose(stateReg == ST_WRITE) ##[1:WR_MAX] writeDone);
	c_read: cover property (startRd ##[1:4] readDone);
	c_ignored: cover property (busReq.wr && hitCtrl &&
		busReq.wdata[CTL_WT] && !wrEnReg);
	c_set_clear: cover property (writeDone && nvmIrqClear);
	c_rd_ignored: cover property (busReq.wr && hitCtrl &&
		busReq.wdata[CTL_RD] && !rdEnReg);

endmodule : ebac_nvm_ctrl

// ==== ebac_tb.sv ====
// Purpose: self-checking bench for the byte-wide store controller
// Assumes: short write timer parameters keep the run brief
// Notes:   every register is reached through the core data bus port
`define CHK(what, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			bad_count++; \
			$display("mismatch %s exp %h got %h", what, exp, got); \
		end \
	end

module testbench
	import ebac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==================================================================
	// signals and design
	localparam int DIV_TB   = 8;
	localparam int TICKS_TB = 2;
	logic          clk_sys        = 1'b0;
	logic          reset          = 1'b1;
	ebac_bus_req_t busReq         = '0;
	logic [7:0]    busRdata;
	logic          busRvalid;
	logic          nvmIrqClear    = 1'b0;
	logic          multiFuncClear = 1'b0;
	logic          nvmIrqFlag;
	logic          multiFuncFlag;
	int            bad_count      = 0;
	int            cmp_count      = 0;
	int            cycleCount     = 0;

	ebac_nvm_ctrl #(
		.RD_CYCLES   (READ_CYCLES),
		.TICK_DIVIDE (DIV_TB),
		.WR_TICKS    (TICKS_TB)
	) dut (
		.clk_sys        (clk_sys),
		.reset          (reset),
		.busReq         (busReq),
		.busRdata       (busRdata),
		.busRvalid      (busRvalid),
		.nvmIrqClear    (nvmIrqClear),
		.multiFuncClear (multiFuncClear),
		.nvmIrqFlag     (nvmIrqFlag),
		.multiFuncFlag  (multiFuncFlag)
	);

	always #10 clk_sys = ~clk_sys;

	// run is a few hundred cycles; ceiling leaves wide margin
	always @(posedge clk_sys) begin
		cycleCount++;
		if (cycleCount == 5000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic final_report();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	// ==================================================================
	// bus cycles, entered and left at a falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
			input logic ind);
		busReq = '{1'b1, 1'b0, ind, a, d};
		@(negedge clk_sys);
		busReq = '0;
		@(negedge clk_sys);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic ind,
			output logic [7:0] d);
		busReq = '{1'b0, 1'b1, ind, a, 8'h00};
		@(negedge clk_sys);
		`CHK("read valid", 1'b1, busRvalid)
		d = busRdata;
		busReq = '0;
		@(negedge clk_sys);
	endtask : rd

	// bounded wait for a self-clearing start bit
	task automatic poll(input int b);
		logic [7:0] v;
		v = 8'hff;
		for (int i = 0; i < 100 && v[b] !== 1'b0; i++) begin
			rd(OFS_CTRL, 1'b1, v);
		end
		`CHK("start bit cleared", 1'b0, v[b])
	endtask : poll

	// ==================================================================
	// scenarios
	task automatic t_reset();
		logic [7:0] v;
		rd(OFS_LOC, 1'b0, v);
		`CHK("location reset", 8'h00, v)
		rd(OFS_BUF, 1'b0, v);
		`CHK("buffer reset", 8'h00, v)
		rd(OFS_BANK, 1'b0, v);
		`CHK("bank reset", 8'h00, v)
		rd(OFS_CTRL, 1'b1, v);
		`CHK("control hidden in bank 0", 8'h00, v)
		wr(OFS_BANK, 8'h01, 1'b0);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("control reset", 8'h00, v)
	endtask : t_reset

	task automatic t_regs();
		logic [7:0] v;
		wr(OFS_LOC, 8'hff, 1'b0);
		rd(OFS_LOC, 1'b0, v);
		`CHK("location width", 8'h1f, v)
		wr(OFS_BUF, 8'h5a, 1'b0);
		rd(OFS_BUF, 1'b0, v);
		`CHK("buffer byte", 8'h5a, v)
		rd(OFS_BUF, 1'b1, v);
		`CHK("buffer via bank 1", 8'h5a, v)
		wr(OFS_CTRL, 8'hf2, 1'b1);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("control upper bits", 8'h02, v)
		wr(OFS_CTRL, 8'h08, 1'b0);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("control direct write", 8'h02, v)
		rd(8'h30, 1'b0, v);
		`CHK("unmapped read", 8'h00, v)
		wr(OFS_CTRL, 8'h00, 1'b1);
	endtask : t_regs

	task automatic t_guard();
		logic [7:0] v;
		wr(OFS_CTRL, 8'h04, 1'b1);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("write start without enable", 8'h00, v)
		wr(OFS_CTRL, 8'h0c, 1'b1);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("enable with write start", 8'h08, v)
		repeat (20) @(negedge clk_sys);
		`CHK("no write end flag", 1'b0, nvmIrqFlag)
		wr(OFS_CTRL, 8'h01, 1'b1);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("read start without enable", 8'h00, v)
		wr(OFS_CTRL, 8'h03, 1'b1);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("enable with read start", 8'h02, v)
		rd(OFS_BUF, 1'b0, v);
		`CHK("buffer untouched", 8'h5a, v)
		wr(OFS_CTRL, 8'h00, 1'b1);
	endtask : t_guard

	task automatic t_write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		wr(OFS_CTRL, 8'h08, 1'b1);
		wr(OFS_LOC, a, 1'b0);
		wr(OFS_BUF, d, 1'b0);
		wr(OFS_CTRL, 8'h08, 1'b1);
		wr(OFS_CTRL, 8'h0c, 1'b1);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("write busy", 8'h0c, v)
		// late overwrite lands while the write is still running
		wr(OFS_BUF, ~d, 1'b0);
		poll(CTL_WT);
		`CHK("store flag", 1'b1, nvmIrqFlag)
		`CHK("shared flag", 1'b1, multiFuncFlag)
		nvmIrqClear = 1'b1;
		multiFuncClear = 1'b1;
		@(negedge clk_sys);
		nvmIrqClear = 1'b0;
		multiFuncClear = 1'b0;
		@(negedge clk_sys);
		`CHK("store flag cleared", 1'b0, nvmIrqFlag)
		`CHK("shared flag cleared", 1'b0, multiFuncFlag)
		wr(OFS_CTRL, 8'h02, 1'b1);
		wr(OFS_LOC, a, 1'b0);
		wr(OFS_CTRL, 8'h03, 1'b1);
		poll(CTL_RD);
		rd(OFS_BUF, 1'b0, v);
		`CHK("read back byte", d, v)
		repeat (5) @(negedge clk_sys);
		rd(OFS_BUF, 1'b0, v);
		`CHK("byte held", d, v)
		wr(OFS_CTRL, 8'h00, 1'b1);
	endtask : t_write

	// second reset mid-run: registers clear, stored bytes survive
	task automatic t_rereset();
		logic [7:0] v;
		wr(OFS_CTRL, 8'h0a, 1'b1);
		reset = 1'b1;
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		rd(OFS_BANK, 1'b0, v);
		`CHK("bank after reset", 8'h00, v)
		rd(OFS_LOC, 1'b0, v);
		`CHK("location after reset", 8'h00, v)
		rd(OFS_BUF, 1'b0, v);
		`CHK("buffer after reset", 8'h00, v)
		rd(OFS_CTRL, 1'b1, v);
		`CHK("control hidden after reset", 8'h00, v)
		wr(OFS_BANK, 8'h01, 1'b0);
		rd(OFS_CTRL, 1'b1, v);
		`CHK("enables after reset", 8'h00, v)
		wr(OFS_CTRL, 8'h02, 1'b1);
		wr(OFS_LOC, 8'h05, 1'b0);
		wr(OFS_CTRL, 8'h03, 1'b1);
		poll(CTL_RD);
		rd(OFS_BUF, 1'b0, v);
		`CHK("byte kept over reset", 8'ha5, v)
		wr(OFS_CTRL, 8'h00, 1'b1);
	endtask : t_rereset

	// ==================================================================
	// main sequence
	initial begin
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		t_reset();
		t_regs();
		t_guard();
		t_write(8'h05, 8'ha5);
		t_write(8'h1f, 8'h3c);
		t_rereset();
		final_report();
	end

endmodule : testbench
